//--- sbg_pkg.sv
package sbg_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] ADR_BAUD  = 8'h00;
  localparam logic [7:0] ADR_BUF   = 8'h04;
  localparam logic [7:0] ADR_CON1  = 8'h08;
  localparam logic [7:0] ADR_CON2  = 8'h0C;
  localparam logic [7:0] ADR_CON3  = 8'h10;
  localparam logic [7:0] ADR_MASK  = 8'h14;
  localparam logic [7:0] ADR_STAT  = 8'h18;

  // reset values
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam logic [1:0] RST_STAT  = 2'h0;

  // field positions
  localparam int CON1_WCOL   = 7;
  localparam int CON1_EN     = 5;
  localparam int CON1_CKP    = 4;
  localparam int CON2_STOP   = 2;
  localparam int STAT_STOP   = 4;
  localparam int STAT_XFER   = 2;
  localparam int STAT_BF     = 0;

  // mode field codes
  localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
  localparam logic [3:0] MODE_SPI_BRG    = 4'hA;

  // timing: counter steps every TICK_CLKS system clocks
  localparam logic [9:0] TICK_CLKS  = 10'h002;
  localparam logic [4:0] HALVES_SPI = 5'h10;
  localparam logic [4:0] HALVES_I2C = 5'h12;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
  } sbg_wb_req_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_STOP = 3'b100
  } sbg_state_e;

  function automatic logic sbg_is_i2c(input logic [7:0] con1);
    sbg_is_i2c = con1[CON1_EN] && (con1[3:0] == MODE_I2C_MASTER);
  endfunction : sbg_is_i2c

  function automatic logic sbg_is_spi(input logic [7:0] con1);
    sbg_is_spi = con1[CON1_EN] && (con1[3:0] == MODE_SPI_BRG);
  endfunction : sbg_is_spi

endpackage : sbg_pkg

//--- sbg_divider_counter.sv
`timescale 1ns/1ps
module sbg_divider_counter
  import sbg_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // control
  input  wire logic       tick,
  input  wire logic       load,
  input  wire logic       run,
  input  wire logic [7:0] reload,
  // state
  output logic      [7:0] count,
  output logic            rollover
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  assign count    = cnt_q;
  assign rollover = run && tick && !load && (cnt_q == 8'h00);

  always_comb
  begin
    cnt_d = cnt_q;
    if (load || rollover)
      cnt_d = reload;
    else if (run && tick)
      cnt_d = cnt_q - 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cnt_q <= RST_REG;
    else
      cnt_q <= cnt_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_reload_from_reg: assert property (
    rollover |=> cnt_q == $past(reload))
    else $error("counter did not reload from reload value");

  a_step_per_tick: assert property (
    (run && tick && !load && cnt_q != 8'h00) |=> cnt_q == $past(cnt_q) - 8'h01)
    else $error("counter did not step down on tick");

  a_hold_off_tick: assert property (
    (!tick && !load) |=> cnt_q == $past(cnt_q))
    else $error("counter moved without a tick");

endmodule : sbg_divider_counter

//--- sbg_baud_gen.sv
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module sbg_baud_gen
  import sbg_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // wishbone slave
  input  wire sbg_wb_req_s wb_req,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // serial clock pin
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  // status
  output logic             busy
);

  sbg_state_e st_q, st_d;
  logic [7:0] baud_q, baud_d;
  logic [7:0] buf_q, buf_d;
  logic [7:0] con1_q, con1_d;
  logic [7:0] con2_q, con2_d;
  logic [7:0] con3_q, con3_d;
  logic [7:0] mask_q, mask_d;
  logic [1:0] stat_sw_q, stat_sw_d;
  logic       bf_q, bf_d;
  logic       stop_seen_q, stop_seen_d;
  logic       sclk_q, sclk_d;
  logic [4:0] halves_q, halves_d;
  logic       ack_q, ack_d;
  logic [7:0] rd_q, rd_d;
  logic       tick_q, tick_d;
  logic       scl_m_q, scl_s_q;

  logic       i2c, spi, wr, load, stretch, run, rollover;
  logic [7:0] cnt;
  logic [7:0] rd_mux;
  logic [7:0] stat_rd;
  logic [4:0] last_half;

  assign i2c       = sbg_is_i2c(con1_q);
  assign spi       = sbg_is_spi(con1_q);
  assign last_half = i2c ? HALVES_I2C : HALVES_SPI;
  // write lands at the edge where the master sees ack
  assign wr        = wb_req.cyc && wb_req.stb && wb_req.we && ack_q && wb_req.sel[0];
  // a released clock held low by a slave freezes the divider at its reload
  assign stretch   = i2c && sclk_q && !scl_s_q && (st_q != ST_IDLE);
  assign run       = (st_q != ST_IDLE) && !stretch;
  assign stat_rd   = {stat_sw_q, 1'b0, stop_seen_q, 1'b0, st_q != ST_IDLE, 1'b0, bf_q};

  // one counter for both modes
  sbg_divider_counter u_div (
    .clk      (clk),
    .srst     (srst),
    .tick     (tick_q),
    .load     (load || stretch),
    .run      (run),
    .reload   (baud_q),
    .count    (cnt),
    .rollover (rollover)
  );

  always_comb
  begin
    unique case (wb_req.adr)
      ADR_BAUD: rd_mux = baud_q;
      ADR_BUF:  rd_mux = buf_q;
      ADR_CON1: rd_mux = con1_q;
      ADR_CON2: rd_mux = con2_q;
      ADR_CON3: rd_mux = con3_q;
      ADR_MASK: rd_mux = mask_q;
      ADR_STAT: rd_mux = stat_rd;
      default:  rd_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    st_d        = st_q;
    baud_d      = baud_q;
    buf_d       = buf_q;
    con1_d      = con1_q;
    con2_d      = con2_q;
    con3_d      = con3_q;
    mask_d      = mask_q;
    stat_sw_d   = stat_sw_q;
    bf_d        = bf_q;
    stop_seen_d = stop_seen_q;
    sclk_d      = sclk_q;
    halves_d    = halves_q;
    load        = 1'b0;
    tick_d      = !tick_q;
    ack_d       = wb_req.cyc && wb_req.stb && !ack_q;
    rd_d        = ack_d ? rd_mux : rd_q;
    if (wr)
    begin
      unique case (wb_req.adr)
        ADR_BAUD: baud_d = wb_req.dat[7:0];
        ADR_BUF:
          if (st_q == ST_IDLE)
          begin
            buf_d = wb_req.dat[7:0];
            if (i2c || spi)
            begin
              st_d        = ST_XFER;
              load        = 1'b1;
              halves_d    = 5'h00;
              bf_d        = 1'b1;
              stop_seen_d = 1'b0;
              sclk_d      = i2c ? 1'b0 : con1_q[CON1_CKP];
            end
          end
        ADR_CON1: con1_d = {con1_q[CON1_WCOL] && wb_req.dat[CON1_WCOL], wb_req.dat[6:0]};
        ADR_CON2:
        begin
          con2_d = wb_req.dat[7:0];
          if (wb_req.dat[CON2_STOP] && i2c && st_q == ST_IDLE)
          begin
            st_d   = ST_STOP;
            sclk_d = 1'b1;
            load   = 1'b1;
          end
          else
            con2_d[CON2_STOP] = 1'b0;
        end
        ADR_CON3: con3_d    = wb_req.dat[7:0];
        ADR_MASK: mask_d    = wb_req.dat[7:0];
        ADR_STAT: stat_sw_d = wb_req.dat[7:6];
        default:  ;
      endcase
    end
    // collision flag set wins over a software clear
    if (wr && wb_req.adr == ADR_BUF && st_q != ST_IDLE)
      con1_d[CON1_WCOL] = 1'b1;
    unique case (st_q)
      ST_IDLE: ;
      ST_XFER:
        if (rollover)
        begin
          sclk_d   = !sclk_q;
          halves_d = halves_q + 5'h01;
          if (halves_q == last_half - 5'h01)
          begin
            st_d = ST_IDLE;
            bf_d = 1'b0;
          end
        end
      ST_STOP:
        if (rollover)
        begin
          st_d              = ST_IDLE;
          con2_d[CON2_STOP] = 1'b0;
          stop_seen_d       = 1'b1;
        end
      default: st_d = ST_IDLE;
    endcase
    if (!con1_q[CON1_EN])
    begin
      st_d              = ST_IDLE;
      bf_d              = 1'b0;
      stop_seen_d       = 1'b0;
      con2_d[CON2_STOP] = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q        <= ST_IDLE;
      baud_q      <= RST_REG;
      buf_q       <= RST_REG;
      con1_q      <= RST_REG;
      con2_q      <= RST_REG;
      con3_q      <= RST_REG;
      mask_q      <= RST_REG;
      stat_sw_q   <= RST_STAT;
      bf_q        <= 1'b0;
      stop_seen_q <= 1'b0;
      sclk_q      <= 1'b1;
      halves_q    <= 5'h00;
      ack_q       <= 1'b0;
      rd_q        <= RST_REG;
      tick_q      <= 1'b0;
      scl_m_q     <= 1'b1;
      scl_s_q     <= 1'b1;
    end
    else
    begin
      st_q        <= st_d;
      baud_q      <= baud_d;
      buf_q       <= buf_d;
      con1_q      <= con1_d;
      con2_q      <= con2_d;
      con3_q      <= con3_d;
      mask_q      <= mask_d;
      stat_sw_q   <= stat_sw_d;
      bf_q        <= bf_d;
      stop_seen_q <= stop_seen_d;
      sclk_q      <= sclk_d;
      halves_q    <= halves_d;
      ack_q       <= ack_d;
      rd_q        <= rd_d;
      tick_q      <= tick_d;
      scl_m_q     <= scl_i;
      scl_s_q     <= scl_m_q;
    end
  end

  // i2c is open drain, spi drives both levels
  assign scl_o    = spi ? sclk_q : 1'b0;
  assign scl_oe_n = !(spi || (i2c && !sclk_q));
  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h000000, rd_q};
  assign busy     = (st_q != ST_IDLE);

  // helper: clocks between rollovers
  logic [9:0] gap_q;
  always_ff @(posedge clk)
  begin
    if (srst || rollover)
      gap_q <= 10'h001;
    else if (gap_q != 10'h3FF)
      gap_q <= gap_q + 10'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_buf_start;
    wr && wb_req.adr == ADR_BUF && st_q == ST_IDLE && (i2c || spi);
  endsequence

  a_start_on_write: assert property (
    s_buf_start |=> st_q == ST_XFER && cnt == $past(baud_q))
    else $error("buffer write did not start the divider");

  a_idle_holds_clock: assert property (
    (st_q == ST_IDLE && !(wr && (wb_req.adr == ADR_CON2 || wb_req.adr == ADR_BUF))) |=> $stable(sclk_q))
    else $error("serial clock moved while stopped");

  a_toggle_on_roll: assert property (
    (st_q == ST_XFER && rollover) |=> sclk_q != $past(sclk_q))
    else $error("clock phase did not advance on rollover");

  a_shared_divider: assert property (
    (st_q == ST_XFER && !rollover) |=> $stable(sclk_q))
    else $error("clock phase moved without divider rollover");

  a_half_period: assert property (
    (st_q == ST_XFER && spi && rollover && halves_q != 5'h00 && $stable(baud_q))
      |-> gap_q == ({2'b00, baud_q} + 10'h001) * TICK_CLKS)
    else $error("half period not reload plus one times two clocks");

  a_stop_waits_high: assert property (
    (st_q == ST_STOP && !scl_s_q) |=> st_q == ST_STOP && cnt == $past(baud_q))
    else $error("stop counted while clock line low");

  a_byte_length: assert property (
    (st_q == ST_XFER && rollover && halves_q == last_half - 5'h01 && con1_q[CON1_EN])
      |=> st_q == ST_IDLE && !bf_q)
    else $error("operation did not end after its half periods");

  a_ack_one_cycle: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

endmodule : sbg_baud_gen

//--- sbg_scl_slave.sv
`timescale 1ns/1ps
module sbg_scl_slave
(
  // pin from the generator
  input  wire logic scl_o,
  input  wire logic scl_oe_n,
  // slave stretching
  input  wire logic hold_low,
  // resolved line
  output logic      scl_i
);
  // pull-up when released, a slave may hold the line low
  assign scl_i = scl_oe_n ? ~hold_low : scl_o;
endmodule : sbg_scl_slave

//--- sbg_baud_gen_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module sbg_baud_gen_tb_top
  import sbg_pkg::*;
;
  logic        clk = 0;
  logic        srst = 1;
  logic        hold = 0;
  sbg_wb_req_s req = '0;
  logic [31:0] rd;
  logic        ack;
  logic        line;
  logic        so;
  logic        soe;
  logic        busy;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc_n = 0;
  int          tg;
  int          iv;
  int          k;
  logic [31:0] q;
  typedef struct { logic [7:0] c1; logic [7:0] r; int h; } sbg_row_s;
  // spi rows and i2c rows share one counter; i2c reloads stay above 2
  sbg_row_s rows[5] = '{'{8'h2A, 8'h01, 16}, '{8'h3A, 8'h03, 16}, '{8'h2A, 8'h09, 16},
                    '{8'h28, 8'h03, 18}, '{8'h28, 8'h04, 18}};

  sbg_baud_gen dut (.clk(clk), .srst(srst), .wb_req(req), .wb_dat_o(rd), .wb_ack_o(ack),
                    .scl_i(line), .scl_o(so), .scl_oe_n(soe), .busy(busy));
  sbg_scl_slave peer (.scl_o(so), .scl_oe_n(soe), .hold_low(hold), .scl_i(line));

  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 30000)
    begin
      fails++;
      final_report();
    end
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    req.cyc <= 1; req.stb <= 1; req.we <= w; req.adr <= a; req.dat <= {24'h0, d}; req.sel <= 4'hF;
    // no wait limit here: only the bench timeout ends a hung request
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    req.cyc <= 0; req.stb <= 0; req.we <= 0;
    @(posedge clk);
  endtask : wb

  task automatic xfer(input logic [7:0] c1, input logic [7:0] r);
    int last;
    logic prev;
    wb(1, ADR_BAUD, r);
    wb(1, ADR_CON1, c1);
    wb(1, ADR_BUF, 8'h5A);
    // start sets the first level (CKP for spi, low for i2c) before prev is taken; only divider toggles count
    prev = line;
    tg = 0; iv = 0; last = 0;
    for (k = 0; k < 4000 && (k < 2 || busy); k++)
    begin
      @(posedge clk); #1;
      if (line !== prev)
      begin
        if (tg > 0) iv = k - last;
        tg++; last = k; prev = line;
      end
    end
  endtask : xfer

  task final_report;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    wb(0, ADR_STAT, 8'h00); `CHK("stat", 32'h0, q)
    wb(0, 8'h1C, 8'h00); `CHK("unmapped", 32'h0, q)
    wb(1, ADR_BAUD, 8'hA5); wb(0, ADR_BAUD, 8'h00); `CHK("baud", 32'hA5, q)
    $display("test regs done");
    foreach (rows[i])
    begin
      xfer(rows[i].c1, rows[i].r);
      `CHK("toggles", rows[i].h, tg)
      if (rows[i].h == 16) `CHK("half", 2 * (rows[i].r + 1), iv)
      q = {31'h0, line};
      repeat (20) @(posedge clk);
      `CHK("held", q, {31'h0, line})
      if (rows[i].h == 16) `CHK("level", {31'h0, rows[i].c1[CON1_CKP]}, q)
      $display("test row %0d done", i);
    end
    wb(1, ADR_CON1, 8'h2A); wb(1, ADR_BAUD, 8'h03); wb(1, ADR_BUF, 8'h11);
    `CHK("busy", 1'b1, busy)
    wb(1, ADR_BUF, 8'h22); wb(0, ADR_CON1, 8'h00);
    `CHK("wcol", 1'b1, q[CON1_WCOL])
    wb(0, ADR_BUF, 8'h00); `CHK("buf kept", 32'h11, q)
    for (k = 0; k < 400 && busy; k++) @(posedge clk);
    $display("test collision done");
    wb(1, ADR_CON1, 8'h28);
    hold <= 1;
    wb(1, ADR_CON2, 8'h04);
    repeat (30) @(posedge clk);
    `CHK("stretch", 1'b1, busy)
    hold <= 0;
    for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk);
    `CHK("stop end", 1'b1, k >= 8 && k <= 14)
    wb(0, ADR_STAT, 8'h00); `CHK("stop flag", 1'b1, q[STAT_STOP])
    wb(0, ADR_CON2, 8'h00); `CHK("stop bit", 1'b0, q[CON2_STOP])
    $display("test stop done");
    wb(1, ADR_CON1, 8'h2A); wb(1, ADR_BUF, 8'h33);
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    #1;
    `CHK("rst busy", 1'b0, busy)
    `CHK("rst oe", 1'b1, soe)
    $display("test reset done");
    final_report();
  end
endmodule : sbg_baud_gen_tb_top
